// file: rtl/lt_override_regs.sv
// Link training override register bank for lanes 1 to 3, APB slave.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module lt_override_regs
   import lt_override_pkg::*;
(
   input  wire logic                     CLK_IN,
   input  wire logic                     RST_IN,
   // APB slave
   input  wire logic                     PSEL_IN,
   input  wire logic                     PENABLE_IN,
   input  wire logic                     PWRITE_IN,
   input  wire logic [lt_override_pkg::ADDR_W-1:0] PADDR_IN,
   input  wire logic [lt_override_pkg::DATA_W-1:0] PWDATA_IN,
   output logic      [lt_override_pkg::DATA_W-1:0] PRDATA_OUT,
   output logic                          PREADY_OUT,
   output logic                          PSLVERR_OUT,
   // Status bytes from the link training logic, same clock
   input  wire logic [7:0]               LANE1_STATUS_IN,
   input  wire logic [7:0]               LANE2_STATUS_IN,
   input  wire logic [7:0]               LANE3_STATUS_IN,
   // Strobes to the link training logic, bit 0 is lane 1
   output logic      [2:0]               TX_COEF_SEND_OUT,
   output logic      [2:0]               RX_COEF_APPLY_OUT,
   // Coefficient fields to the link training logic
   output logic      [7:0]               TX_COEF_LANE1_OUT,
   output logic      [7:0]               TX_COEF_LANE2_OUT,
   output logic      [7:0]               TX_COEF_LANE3_OUT,
   output logic      [7:0]               RX_COEF_LANE1_OUT,
   output logic      [7:0]               RX_COEF_LANE2_OUT,
   output logic      [7:0]               RX_COEF_LANE3_OUT,
   // Override enables, visible to the link training logic
   output logic                          PARTNER_OVR_EN_OUT,
   output logic                          LOCAL_OVR_EN_OUT,
   // Level interrupt
   output logic                          IRQ_OUT
);

   import lt_override_pkg::*;

   // ------------------------------------------------------------
   // Bus phase decode
   // ------------------------------------------------------------

   logic              setup_phase;
   logic              access_done;
   logic              wr_done;
   logic [7:0]        word_idx;
   logic              aligned;

   // Setup cycle, and the edge at which an access completes
   assign setup_phase = PSEL_IN & ~PENABLE_IN;
   assign access_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
   assign wr_done     = access_done & PWRITE_IN;

   // Word index; a byte address off a word boundary maps to nothing
   assign word_idx = PADDR_IN[ADDR_W-1:2];
   assign aligned  = (PADDR_IN[1:0] == 2'h0);

   // ------------------------------------------------------------
   // Address hits
   // ------------------------------------------------------------

   logic              hit_enable;
   logic              hit_control;
   logic              hit_status;
   logic              hit_irq_status;
   logic              hit_irq_mask;
   logic [LANES-1:0]  hit_coef;
   logic              mapped;

   // Fixed registers
   assign hit_enable     = aligned & (word_idx == IDX_OVR_ENABLE);
   assign hit_control    = aligned & (word_idx == IDX_LANE_CONTROL);
   assign hit_status     = aligned & (word_idx == IDX_LANE_STATUS);
   assign hit_irq_status = aligned & (word_idx == IDX_IRQ_STATUS);
   assign hit_irq_mask   = aligned & (word_idx == IDX_IRQ_MASK);

   // Anything else answers with an error and reads as zero
   assign mapped = hit_enable | hit_control | hit_status
                 | hit_irq_status | hit_irq_mask | (|hit_coef);

   // ------------------------------------------------------------
   // Override enable register
   // ------------------------------------------------------------

   logic              partner_ovr_en;
   logic              local_ovr_en;

   // Global enables gate every lane's strobes
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         partner_ovr_en <= OVR_RESET;
         local_ovr_en   <= OVR_RESET;
      end
      else if (wr_done & hit_enable)
      begin
         partner_ovr_en <= PWDATA_IN[BIT_PARTNER_OVR_EN];
         local_ovr_en   <= PWDATA_IN[BIT_LOCAL_OVR_EN];
      end
   end

   assign PARTNER_OVR_EN_OUT = partner_ovr_en;
   assign LOCAL_OVR_EN_OUT   = local_ovr_en;

   // ------------------------------------------------------------
   // Per-lane strobes and coefficient registers
   // ------------------------------------------------------------

   logic [DATA_W-1:0] coef [LANES];
   logic [LANES-1:0]  tx_req;
   logic [LANES-1:0]  rx_req;
   logic [LANES-1:0]  tx_pulse;
   logic [LANES-1:0]  rx_pulse;

   // Each lane decodes its own coefficient word and strobe bits
   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      localparam logic [7:0] LANE_IDX = 8'(IDX_COEF_LANE1 + IDX_COEF_STRIDE * 8'(l));

      assign hit_coef[l] = aligned & (word_idx == LANE_IDX);

      // Only a written one raises a request; a zero leaves things alone
      assign tx_req[l] = wr_done & hit_control
                       & PWDATA_IN[BIT_TX_STROBE_BASE + l];   // [R02] [R03] [R04] [R12]
      assign rx_req[l] = wr_done & hit_control
                       & PWDATA_IN[BIT_RX_STROBE_BASE + l];   // [R05] [R07] [R08] [R12]

      lane_strobe_unit u_lane
      (
         .clk_in        (CLK_IN),
         .rst_in        (RST_IN),
         .coef_wr_in    (wr_done & hit_coef[l]),
         .wdata_in      (PWDATA_IN),
         .tx_req_in     (tx_req[l]),
         .rx_req_in     (rx_req[l]),
         .partner_en_in (partner_ovr_en),
         .local_en_in   (local_ovr_en),
         .coef_out      (coef[l]),
         .tx_pulse_out  (tx_pulse[l]),
         .rx_pulse_out  (rx_pulse[l])
      );
   end

   // Strobes leave straight from the lane flip-flops
   assign TX_COEF_SEND_OUT  = tx_pulse;   // [R11]
   assign RX_COEF_APPLY_OUT = rx_pulse;   // [R05] [R07] [R08]

   // Transmit coefficients for the partner, low byte of each lane word
   assign TX_COEF_LANE1_OUT = coef[0][TX_COEF_LSB +: COEF_W];   // [R11]
   assign TX_COEF_LANE2_OUT = coef[1][TX_COEF_LSB +: COEF_W];
   assign TX_COEF_LANE3_OUT = coef[2][TX_COEF_LSB +: COEF_W];

   // Local equalizer coefficients, bits 23:16 of each lane word
   assign RX_COEF_LANE1_OUT = coef[0][RX_COEF_LSB +: COEF_W];   // [R05]
   assign RX_COEF_LANE2_OUT = coef[1][RX_COEF_LSB +: COEF_W];   // [R07]
   assign RX_COEF_LANE3_OUT = coef[2][RX_COEF_LSB +: COEF_W];   // [R08]

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------

   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_events;
   logic [IRQ_W-1:0]  irq_clear;
   logic [IRQ_W-1:0]  next_irq_status;

   // One event per accepted strobe; refused strobes raise nothing
   assign irq_events = {rx_pulse, tx_pulse};

   // Write one to clear
   assign irq_clear = (wr_done & hit_irq_status) ? PWDATA_IN[IRQ_W-1:0] : IRQ_RESET;

   // Set wins over clear, so an event in the clearing cycle survives
   assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

   // Sticky event bits
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         irq_status <= IRQ_RESET;
      end
      else
      begin
         irq_status <= next_irq_status;
      end
   end

   // Mask, same layout as status; one enables the bit
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         irq_mask <= IRQ_RESET;
      end
      else if (wr_done & hit_irq_mask)
      begin
         irq_mask <= PWDATA_IN[IRQ_W-1:0];
      end
   end

   // Registered output; it trails the status bits by one cycle
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         IRQ_OUT <= 1'b0;
      end
      else
      begin
         IRQ_OUT <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------

   logic [DATA_W-1:0] next_rdata;

   // Strobe bits always read as zero: they live a single cycle and a
   // read can never catch one, so showing them would only confuse
   always_comb
   begin
      next_rdata = RDATA_RESET;
      if (hit_enable)
      begin
         next_rdata[BIT_PARTNER_OVR_EN] = partner_ovr_en;
         next_rdata[BIT_LOCAL_OVR_EN]   = local_ovr_en;
      end
      if (hit_control)
      begin
         next_rdata = RDATA_RESET;   // [R12]
      end
      if (hit_status)
      begin
         // Lane 0 byte belongs elsewhere and reads as zero here
         next_rdata[1*STATUS_BYTE_W +: STATUS_BYTE_W] = LANE1_STATUS_IN;   // [R09]
         next_rdata[2*STATUS_BYTE_W +: STATUS_BYTE_W] = LANE2_STATUS_IN;   // [R09]
         next_rdata[3*STATUS_BYTE_W +: STATUS_BYTE_W] = LANE3_STATUS_IN;
      end
      if (hit_irq_status)
      begin
         next_rdata[IRQ_W-1:0] = irq_status;
      end
      if (hit_irq_mask)
      begin
         next_rdata[IRQ_W-1:0] = irq_mask;
      end
      for (int i = 0; i < LANES; i++)
      begin
         if (hit_coef[i])
         begin
            next_rdata = coef[i];
         end
      end
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------

   // Ready rises for the access cycle that follows each setup cycle,
   // giving one access cycle per transfer and no wait states
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PREADY_OUT <= 1'b0;
      end
      else
      begin
         PREADY_OUT <= setup_phase;
      end
   end

   // Error for unmapped or misaligned addresses, reads and writes alike
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PSLVERR_OUT <= 1'b0;
      end
      else
      begin
         PSLVERR_OUT <= setup_phase & ~mapped;
      end
   end

   // Read data captured at the end of setup and held until the next read
   // Status bytes are therefore as they stood at that edge
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PRDATA_OUT <= RDATA_RESET;
      end
      else if (setup_phase & ~PWRITE_IN)
      begin
         PRDATA_OUT <= next_rdata;
      end
   end

   // Frame lock error judgement is left to software, which compares the
   // lane taps against their initial values; nothing here decides it [R10]

endmodule

// file: rtl/lt_override_pkg.sv
// Constants for the link training coefficient override register bank.
//
// Behaviour
// R01: Transmit coefficient strobes act only while the partner override enable bit is 1.
// R02: Lane 1 transmit strobe, bit 5, is ignored while partner override enable is 0.
// R03: Lane 2 transmit strobe sits at bit 6, resets to 0, read-write.
// R04: Lane 3 transmit strobe sits at bit 7, resets to 0, read-write.
// R05: Lane 1 receive strobe, bit 9, applies lane 1 coefficients 23:16, then clears.
// R06: Receive strobes of any lane act only while local override enable bit is 1.
// R07: Lane 2 receive strobe, bit 10, applies lane 2 coefficients 23:16, then clears.
// R08: Lane 3 receive strobe, bit 11, applies lane 3 coefficients 23:16, then clears.
// R09: Status register repeats the lane 0 byte layout for lanes 1 and 2.
// R10: Software treats frame lock error with unchanged initial taps as unrecoverable.
// R11: Accepted transmit strobe sends the lane coefficients 7:0 to the partner, then clears.
// R12: Strobes read back 0 a cycle after the write; writing 0 changes nothing.
package lt_override_pkg;

   // Lanes served by this bank: lanes 1 to 3
   localparam int LANES = 3;

   // APB byte address width; word index is the address divided by four
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // Register word indices; byte address is four times the index
   localparam logic [7:0] IDX_OVR_ENABLE   = 8'hD0;
   localparam logic [7:0] IDX_LANE_CONTROL = 8'hD1;
   localparam logic [7:0] IDX_LANE_STATUS  = 8'hD2;
   localparam logic [7:0] IDX_COEF_LANE1   = 8'hE1;
   localparam logic [7:0] IDX_COEF_STRIDE  = 8'h04;
   localparam logic [7:0] IDX_IRQ_STATUS   = 8'hF0;
   localparam logic [7:0] IDX_IRQ_MASK     = 8'hF1;

   // Override enable register fields
   localparam int BIT_PARTNER_OVR_EN = 16;
   localparam int BIT_LOCAL_OVR_EN   = 17;

   // Lane control strobe fields, lane 1 at the base, lanes 2 and 3 above it
   localparam int BIT_TX_STROBE_BASE = 5;
   localparam int BIT_RX_STROBE_BASE = 9;

   // Coefficient register fields
   localparam int COEF_W        = 8;
   localparam int TX_COEF_LSB   = 0;
   localparam int RX_COEF_LSB   = 16;

   // Status byte per lane, lane 1 at bits 15:8
   localparam int STATUS_BYTE_W = 8;

   // Interrupt status layout: transmit events low, receive events above
   localparam int IRQ_W      = 6;
   localparam int IRQ_TX_LSB = 0;
   localparam int IRQ_RX_LSB = 3;

   // Values after reset
   localparam logic [31:0] COEF_RESET   = 32'h0000_0000;
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
   localparam logic        STROBE_RESET = 1'b0;
   localparam logic        OVR_RESET    = 1'b0;
   localparam logic [5:0]  IRQ_RESET    = 6'h00;

endpackage

// file: rtl/lane_strobe_unit.sv
// One lane: coefficient register and the two self-clearing update strobes.
`timescale 1ns/1ps

module lane_strobe_unit
   import lt_override_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              coef_wr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              tx_req_in,
   input  wire logic              rx_req_in,
   input  wire logic              partner_en_in,
   input  wire logic              local_en_in,
   output logic      [DATA_W-1:0] coef_out,
   output logic                   tx_pulse_out,
   output logic                   rx_pulse_out
);

   // Coefficient register: transmit field 7:0, local equalizer field 23:16
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         coef_out <= COEF_RESET;
      end
      else if (coef_wr_in)
      begin
         coef_out <= wdata_in;
      end
   end

   // Transmit strobe: gated by partner enable, lives one cycle only
   // A request with the enable low is simply dropped, not held for later
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tx_pulse_out <= STROBE_RESET;
      end
      else
      begin
         tx_pulse_out <= tx_req_in & partner_en_in;   // [R01] [R02] [R11] [R12]
      end
   end

   // Receive strobe: gated by local enable, lives one cycle only
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rx_pulse_out <= STROBE_RESET;
      end
      else
      begin
         rx_pulse_out <= rx_req_in & local_en_in;   // [R05] [R06] [R12]
      end
   end

endmodule

// file: tb/lt_override_regs_checker.sv
// Port-level assertions for the override register bank.
`timescale 1ns/1ps

module lt_override_regs_checker
   import lt_override_pkg::*;
(
   input wire logic              CLK_IN,
   input wire logic              RST_IN,
   input wire logic              PSEL_IN,
   input wire logic              PENABLE_IN,
   input wire logic              PWRITE_IN,
   input wire logic [ADDR_W-1:0] PADDR_IN,
   input wire logic [DATA_W-1:0] PWDATA_IN,
   input wire logic [DATA_W-1:0] PRDATA_OUT,
   input wire logic              PREADY_OUT,
   input wire logic              PSLVERR_OUT,
   input wire logic [7:0]        LANE1_STATUS_IN,
   input wire logic [7:0]        LANE2_STATUS_IN,
   input wire logic [7:0]        LANE3_STATUS_IN,
   input wire logic [2:0]        TX_COEF_SEND_OUT,
   input wire logic [2:0]        RX_COEF_APPLY_OUT,
   input wire logic              PARTNER_OVR_EN_OUT,
   input wire logic              LOCAL_OVR_EN_OUT
);
   default clocking dflt @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   // Decoded bus phases; the master holds the request, so these are stable
   wire logic setup = PSEL_IN && !PENABLE_IN;
   wire logic wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
   wire logic mapped = PADDR_IN inside {{IDX_OVR_ENABLE, 2'b00}, {IDX_LANE_CONTROL, 2'b00},
      {IDX_LANE_STATUS, 2'b00}, {IDX_COEF_LANE1, 2'b00}, {8'hE5, 2'b00}, {8'hE9, 2'b00},
      {IDX_IRQ_STATUS, 2'b00}, {IDX_IRQ_MASK, 2'b00}};

   sequence ctrl_wr_s;
      wr_done && PADDR_IN == {IDX_LANE_CONTROL, 2'b00};
   endsequence
   sequence stat_rd_s;
      setup && !PWRITE_IN && PADDR_IN == {IDX_LANE_STATUS, 2'b00};
   endsequence

   chk_tx_strobe_gated: assert property (ctrl_wr_s ##0 PARTNER_OVR_EN_OUT
      |=> TX_COEF_SEND_OUT == $past(PWDATA_IN[7:5])) else $error("tx strobe pulse wrong");
   chk_tx_strobe_blocked: assert property (ctrl_wr_s ##0 !PARTNER_OVR_EN_OUT
      |=> TX_COEF_SEND_OUT == 3'b000) else $error("tx strobe acted while disabled");
   chk_rx_strobe_gated: assert property (ctrl_wr_s ##0 LOCAL_OVR_EN_OUT
      |=> RX_COEF_APPLY_OUT == $past(PWDATA_IN[11:9])) else $error("rx strobe pulse wrong");
   chk_rx_strobe_blocked: assert property (ctrl_wr_s ##0 !LOCAL_OVR_EN_OUT
      |=> RX_COEF_APPLY_OUT == 3'b000) else $error("rx strobe acted while disabled");
   chk_pulse_self_clear: assert property ((TX_COEF_SEND_OUT | RX_COEF_APPLY_OUT) != 3'b000
      |=> (TX_COEF_SEND_OUT | RX_COEF_APPLY_OUT) == 3'b000) else $error("strobe pulse too long");
   chk_ready_after_setup: assert property (setup |=> PREADY_OUT)
      else $error("ready missing after setup");
   chk_ready_in_access: assert property (PREADY_OUT |-> $past(setup) && PENABLE_IN)
      else $error("ready outside access cycle");
   chk_err_unmapped: assert property (setup |=> PSLVERR_OUT == $past(!mapped))
      else $error("error response wrong");
   chk_status_layout: assert property (stat_rd_s |=> PRDATA_OUT ==
      {$past(LANE3_STATUS_IN), $past(LANE2_STATUS_IN), $past(LANE1_STATUS_IN), 8'h00})
      else $error("status read wrong");
   chk_enable_store: assert property (wr_done && PADDR_IN == {IDX_OVR_ENABLE, 2'b00}
      |=> {LOCAL_OVR_EN_OUT, PARTNER_OVR_EN_OUT} == $past(PWDATA_IN[17:16]))
      else $error("enable bits not stored");
endmodule

// file: tb/tb_lt_override_regs.sv
// Self-checking bench for the override register bank.
`timescale 1ns/1ps

module tb_lt_override_regs;
   import lt_override_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  st [3] = '{8'h00, 8'h00, 8'h00};
   logic [2:0]  tx_send;
   logic [2:0]  rx_apply;
   logic [7:0]  txc [3];
   logic [7:0]  rxc [3];
   logic        p_en;
   logic        l_en;
   logic        irq;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          seen [6];
   int          want [6];
   logic [31:0] rd;
   logic        rd_err;

   lt_override_regs lt_override_regs_i (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .LANE1_STATUS_IN(st[0]), .LANE2_STATUS_IN(st[1]), .LANE3_STATUS_IN(st[2]),
      .TX_COEF_SEND_OUT(tx_send), .RX_COEF_APPLY_OUT(rx_apply), .TX_COEF_LANE1_OUT(txc[0]),
      .TX_COEF_LANE2_OUT(txc[1]), .TX_COEF_LANE3_OUT(txc[2]), .RX_COEF_LANE1_OUT(rxc[0]),
      .RX_COEF_LANE2_OUT(rxc[1]), .RX_COEF_LANE3_OUT(rxc[2]), .PARTNER_OVR_EN_OUT(p_en),
      .LOCAL_OVR_EN_OUT(l_en), .IRQ_OUT(irq));

   always #12.5 clk = ~clk;

   // Count strobe pulses per lane; a hang is cut short by the cycle ceiling
   always @(posedge clk)
   begin
      cycles++;
      for (int i = 0; i < 3; i++)
      begin
         seen[i] += (tx_send[i] === 1'b1);
         seen[i+3] += (rx_apply[i] === 1'b1);
      end
      if (cycles == 6000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [9:0] a(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction

   // One APB transfer; request held until ready is sampled high
   // A slave that never answers is caught by the cycle ceiling, not here
   task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] data);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [9:0] addr, input logic [31:0] exp, input logic err);
      apb(1'b0, addr, '0);
      cmp(name, exp, rd);
      cmp("slave error", {31'h0, err}, {31'h0, rd_err});
   endtask

   // Pulses land the cycle after the write edge, so let them be counted first
   task automatic chk_pulses();
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++)
         cmp("strobe pulses", want[i], seen[i]);
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk("enable", a(IDX_OVR_ENABLE), '0, 1'b0);
      rd_chk("control", a(IDX_LANE_CONTROL), '0, 1'b0);
      rd_chk("irq status", a(IDX_IRQ_STATUS), '0, 1'b0);
      // Every strobe with both enables low does nothing
      apb(1'b1, a(IDX_LANE_CONTROL), 32'h0000_0EE0);
      chk_pulses();
      rd_chk("irq status", a(IDX_IRQ_STATUS), '0, 1'b0);
      // Each enable gates only its own strobe group
      apb(1'b1, a(IDX_OVR_ENABLE), 32'h0001_0000);
      apb(1'b1, a(IDX_LANE_CONTROL), 32'h0000_0EE0);
      for (int i = 0; i < 3; i++)
         want[i] = 1;
      chk_pulses();
      apb(1'b1, a(IDX_OVR_ENABLE), 32'h0002_0000);
      apb(1'b1, a(IDX_LANE_CONTROL), 32'h0000_0EE0);
      for (int i = 3; i < 6; i++)
         want[i] = 1;
      chk_pulses();
      // One strobe at a time, each lane kept apart
      apb(1'b1, a(IDX_OVR_ENABLE), 32'h0003_0000);
      rd_chk("enable", a(IDX_OVR_ENABLE), 32'h0003_0000, 1'b0);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, a(IDX_LANE_CONTROL), 32'h1 << (i < 3 ? 5 + i : 6 + i));
         want[i]++;
         chk_pulses();
      end
      apb(1'b1, a(IDX_LANE_CONTROL), '0);
      chk_pulses();
      rd_chk("control", a(IDX_LANE_CONTROL), '0, 1'b0);
      // Coefficient fields reach the lanes
      for (int l = 0; l < 3; l++)
         apb(1'b1, a(IDX_COEF_LANE1 + 8'(l) * IDX_COEF_STRIDE), 32'h0011_0022 * (l + 1));
      @(posedge clk);
      for (int l = 0; l < 3; l++)
      begin
         cmp("tx coef", 32'h22 * (l + 1), {24'h0, txc[l]});
         cmp("rx coef", 32'h11 * (l + 1), {24'h0, rxc[l]});
      end
      rd_chk("coef lane3", a(8'hE9), 32'h0033_0066, 1'b0);
      st <= '{8'hA5, 8'h3C, 8'h81};
      // Software judges frame lock errors from these bytes and the lane taps
      rd_chk("lane status", a(IDX_LANE_STATUS), 32'h813C_A500, 1'b0);
      // Interrupt: all six events are pending, mask still closed
      rd_chk("irq status", a(IDX_IRQ_STATUS), 32'h0000_003F, 1'b0);
      cmp("irq", '0, {31'h0, irq});
      apb(1'b1, a(IDX_IRQ_MASK), 32'h0000_003F);
      repeat (3) @(posedge clk);
      cmp("irq", 32'h1, {31'h0, irq});
      apb(1'b1, a(IDX_IRQ_STATUS), 32'h0000_0007);
      rd_chk("irq status", a(IDX_IRQ_STATUS), 32'h0000_0038, 1'b0);
      apb(1'b1, a(IDX_IRQ_STATUS), 32'h0000_0038);
      repeat (3) @(posedge clk);
      cmp("irq", '0, {31'h0, irq});
      // Unmapped and misaligned accesses are refused
      rd_chk("unmapped", 10'h3FC, '0, 1'b1);
      apb(1'b1, 10'h346, 32'h0000_0020);
      cmp("misaligned error", 32'h1, {31'h0, rd_err});
      chk_pulses();
      conclude();
   end
endmodule

bind lt_override_regs lt_override_regs_checker lt_override_regs_checker_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
   .LANE1_STATUS_IN(LANE1_STATUS_IN), .LANE2_STATUS_IN(LANE2_STATUS_IN), .LANE3_STATUS_IN(LANE3_STATUS_IN),
   .TX_COEF_SEND_OUT(TX_COEF_SEND_OUT), .RX_COEF_APPLY_OUT(RX_COEF_APPLY_OUT),
   .PARTNER_OVR_EN_OUT(PARTNER_OVR_EN_OUT), .LOCAL_OVR_EN_OUT(LOCAL_OVR_EN_OUT));
